// [hw/sag_addr_gen.sv]
// operand and physical address generation of the segmented core
// assumes decoder requests and register writes on the same core clock
//
// What this block does
// - fourteen 16-bit architectural registers held here
// - four general registers split into byte halves
// - segment offsets are 16 bits, 64K bytes
// - physical address is segment shifted four plus offset
// - code segment for prefetch and immediate fetch
// - stack segment for stack and frame-based references
// - extra segment for string destination references
// - data segment for all other data
// - override prefix replaces the implicit segment of data references only
// - offset sums displacement, base and index
// - offset sum keeps only low 16 bits
// - byte displacement sign extended first
// - direct mode uses displacement alone
// - register indirect uses one pointer register
// - based mode adds displacement to base
// - indexed mode adds displacement to index
// - based indexed adds base and index only
// - based indexed displacement adds all three
// - register or immediate operands also supported
`default_nettype none

module sag_addr_gen
    import sag_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic gp_wr_en_i,
    input wire logic [2:0] gp_wr_idx_i,
    input wire logic gp_wr_byte_i,
    input wire logic gp_wr_hi_i,
    input wire logic [15:0] gp_wr_data_i,
    input wire logic seg_wr_en_i,
    input wire sag_seg_e seg_wr_sel_i,
    input wire logic [15:0] seg_wr_data_i,
    input wire logic instr_ptr_wr_en_i,
    input wire logic [15:0] instr_ptr_wr_data_i,
    input wire logic flags_wr_en_i,
    input wire logic [15:0] flags_wr_data_i,
    input wire logic opnd_req_i,
    input wire logic opnd_imm_sel_i,
    input wire logic [15:0] opnd_imm_i,
    input wire logic [2:0] opnd_reg_idx_i,
    input wire logic opnd_byte_i,
    input wire logic opnd_hi_i,
    input wire logic req_valid_i,
    input wire sag_ref_e req_kind_i,
    input wire sag_mode_e req_mode_i,
    input wire logic req_base_frame_i,
    input wire logic req_idx_dest_i,
    input wire sag_ri_e req_ri_sel_i,
    input wire logic [15:0] req_disp_i,
    input wire logic req_disp_wide_i,
    input wire logic req_ovr_valid_i,
    input wire sag_seg_e req_ovr_seg_i,
    output logic opnd_valid_o,
    output logic [15:0] opnd_data_o,
    output logic addr_valid_o,
    output logic [15:0] eff_addr_o,
    output logic [19:0] phys_addr_o,
    output sag_seg_e seg_used_o,
    output logic [15:0] instr_ptr_o,
    output logic [15:0] flags_o
);

    // =====================================================================
    // general registers and segment choice
    logic [15:0] gp_rd_data;
    logic [15:0] base_gp_reg;
    logic [15:0] frame_base_reg;
    logic [15:0] src_idx_reg;
    logic [15:0] dest_idx_reg;
    logic [15:0] stack_ptr_reg;
    logic [2:0] gp_rd_idx;
    sag_seg_e cur_seg;

    // byte operands read the split register, not the pointer group
    assign gp_rd_idx = opnd_byte_i ? {1'b0, opnd_reg_idx_i[1:0]} :
                       opnd_reg_idx_i;

    sag_gp_file u_gp_file (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(gp_wr_en_i),
        .wr_idx_i(gp_wr_idx_i),
        .wr_byte_i(gp_wr_byte_i),
        .wr_hi_i(gp_wr_hi_i),
        .wr_data_i(gp_wr_data_i),
        .rd_idx_i(gp_rd_idx),
        .rd_data_o(gp_rd_data),
        .base_gp_o(base_gp_reg),
        .frame_base_o(frame_base_reg),
        .src_idx_o(src_idx_reg),
        .dest_idx_o(dest_idx_reg),
        .stack_ptr_o(stack_ptr_reg)
    );

    sag_seg_sel u_seg_sel (
        .kind_i(req_kind_i),
        .mode_i(req_mode_i),
        .base_frame_i(req_base_frame_i),
        .ri_sel_i(req_ri_sel_i),
        .ovr_valid_i(req_ovr_valid_i),
        .ovr_seg_i(req_ovr_seg_i),
        .seg_o(cur_seg)
    );

    // =====================================================================
    // segment registers, pointer and flags
    logic [15:0] seg_regs [NUM_SEG];
    logic [15:0] next_seg_regs [NUM_SEG];
    logic [15:0] instr_ptr_reg;
    logic [15:0] next_instr_ptr;
    logic [15:0] flags_reg;
    logic [15:0] next_flags;

    always_comb begin
        for (int i = 0; i < NUM_SEG; i++) begin
            next_seg_regs[i] = seg_regs[i];
        end
        if (seg_wr_en_i) begin
            next_seg_regs[seg_wr_sel_i] = seg_wr_data_i;
        end
        next_instr_ptr = instr_ptr_wr_en_i ? instr_ptr_wr_data_i :
                         instr_ptr_reg;
        next_flags = flags_wr_en_i ? flags_wr_data_i : flags_reg;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_regs[i] <= SEG_RESET;
            end
            instr_ptr_reg <= INSTR_PTR_RESET;
            flags_reg <= FLAGS_RESET;
        end else begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_regs[i] <= next_seg_regs[i];
            end
            instr_ptr_reg <= next_instr_ptr;
            flags_reg <= next_flags;
        end
    end

    assign instr_ptr_o = instr_ptr_reg;
    assign flags_o = flags_reg;

    // =====================================================================
    // effective address; sums are 16 bits wide so carries drop out
    logic [15:0] base_val;
    logic [15:0] idx_val;
    logic [15:0] disp_val;
    logic [15:0] ea_val;
    logic [15:0] off_val;
    logic [15:0] cur_seg_val;

    always_comb begin
        base_val = req_base_frame_i ? frame_base_reg : base_gp_reg;
        idx_val = req_idx_dest_i ? dest_idx_reg : src_idx_reg;
        disp_val = req_disp_wide_i ? req_disp_i :
                   sag_sext8(req_disp_i[7:0]);
        case (req_mode_i)
            AM_DIRECT: begin
                ea_val = disp_val;
            end
            AM_REG_IND: begin
                case (req_ri_sel_i)
                    RI_SRC_IDX: ea_val = src_idx_reg;
                    RI_DEST_IDX: ea_val = dest_idx_reg;
                    RI_BASE: ea_val = base_gp_reg;
                    default: ea_val = frame_base_reg;
                endcase
            end
            AM_BASED: begin
                ea_val = base_val + disp_val;
            end
            AM_INDEXED: begin
                ea_val = idx_val + disp_val;
            end
            AM_BASED_IDX: begin
                ea_val = base_val + idx_val;
            end
            default: begin
                ea_val = base_val + idx_val + disp_val;
            end
        endcase
        // fetches follow the pointer, stack references the stack pointer
        case (req_kind_i)
            REF_FETCH, REF_IMMED: off_val = instr_ptr_reg;
            REF_STACK: off_val = stack_ptr_reg;
            REF_STR_DST: off_val = dest_idx_reg;
            default: off_val = ea_val;
        endcase
        cur_seg_val = seg_regs[cur_seg];
    end

    // =====================================================================
    // address output stage, one cycle after the request
    logic next_addr_valid;
    logic [15:0] next_eff_addr;
    logic [19:0] next_phys_addr;
    sag_seg_e next_seg_used;

    always_comb begin
        next_addr_valid = req_valid_i;
        next_eff_addr = eff_addr_o;
        next_phys_addr = phys_addr_o;
        next_seg_used = seg_used_o;
        if (req_valid_i) begin
            next_eff_addr = off_val;
            next_seg_used = cur_seg;
            next_phys_addr = sag_phys(cur_seg_val, off_val);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_valid_o <= 1'b0;
            eff_addr_o <= 16'h0000;
            phys_addr_o <= 20'h00000;
            seg_used_o <= SEG_DATA;
        end else begin
            addr_valid_o <= next_addr_valid;
            eff_addr_o <= next_eff_addr;
            phys_addr_o <= next_phys_addr;
            seg_used_o <= next_seg_used;
        end
    end

    // =====================================================================
    // operand path; register data needs the file's read cycle first
    logic opnd_stage;
    logic next_opnd_stage;
    logic stage_imm_sel;
    logic stage_byte;
    logic stage_hi;
    logic [15:0] stage_imm;
    logic next_stage_imm_sel;
    logic next_stage_byte;
    logic next_stage_hi;
    logic [15:0] next_stage_imm;
    logic next_opnd_valid;
    logic [15:0] next_opnd_data;

    always_comb begin
        next_opnd_stage = opnd_req_i;
        next_stage_imm_sel = opnd_req_i ? opnd_imm_sel_i : stage_imm_sel;
        next_stage_byte = opnd_req_i ? opnd_byte_i : stage_byte;
        next_stage_hi = opnd_req_i ? opnd_hi_i : stage_hi;
        next_stage_imm = opnd_req_i ? opnd_imm_i : stage_imm;
        next_opnd_valid = opnd_stage;
        next_opnd_data = opnd_data_o;
        if (opnd_stage) begin
            if (stage_imm_sel) begin
                next_opnd_data = stage_imm;
            end else if (stage_byte) begin
                // byte operands come back zero extended
                next_opnd_data = stage_hi ? {8'h00, gp_rd_data[15:8]} :
                                 {8'h00, gp_rd_data[7:0]};
            end else begin
                next_opnd_data = gp_rd_data;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opnd_stage <= 1'b0;
            stage_imm_sel <= 1'b0;
            stage_byte <= 1'b0;
            stage_hi <= 1'b0;
            stage_imm <= 16'h0000;
            opnd_valid_o <= 1'b0;
            opnd_data_o <= 16'h0000;
        end else begin
            opnd_stage <= next_opnd_stage;
            stage_imm_sel <= next_stage_imm_sel;
            stage_byte <= next_stage_byte;
            stage_hi <= next_stage_hi;
            stage_imm <= next_stage_imm;
            opnd_valid_o <= next_opnd_valid;
            opnd_data_o <= next_opnd_data;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    fetch_code_seg_a: assert property (
        (req_valid_i && (req_kind_i == REF_FETCH || req_kind_i == REF_IMMED))
        |=> addr_valid_o && seg_used_o == SEG_CODE &&
            eff_addr_o == $past(instr_ptr_reg))
        else $error("fetch not in code segment");

    stack_seg_a: assert property (
        (req_valid_i && req_kind_i == REF_STACK)
        |=> seg_used_o == SEG_STACK && eff_addr_o == $past(stack_ptr_reg))
        else $error("stack access not in stack segment");

    frame_seg_a: assert property (
        (req_valid_i && req_kind_i == REF_DATA && !req_ovr_valid_i &&
         req_base_frame_i && req_mode_i == AM_BASED)
        |=> seg_used_o == SEG_STACK)
        else $error("frame based reference not in stack segment");

    string_dst_a: assert property (
        (req_valid_i && req_kind_i == REF_STR_DST)
        |=> seg_used_o == SEG_EXTRA && eff_addr_o == $past(dest_idx_reg))
        else $error("string destination not in extra segment");

    data_default_a: assert property (
        (req_valid_i && req_kind_i == REF_DATA && !req_ovr_valid_i &&
         (req_mode_i == AM_DIRECT || req_mode_i == AM_INDEXED))
        |=> seg_used_o == SEG_DATA)
        else $error("plain data reference not in data segment");

    override_seg_a: assert property (
        (req_valid_i && req_kind_i == REF_DATA && req_ovr_valid_i)
        |=> seg_used_o == $past(req_ovr_seg_i))
        else $error("override prefix ignored");

    direct_sext_a: assert property (
        (req_valid_i && req_kind_i == REF_DATA &&
         req_mode_i == AM_DIRECT && !req_disp_wide_i)
        |=> eff_addr_o == {{8{$past(req_disp_i[7])}}, $past(req_disp_i[7:0])})
        else $error("byte displacement not sign extended");

    based_idx_sum_a: assert property (
        (req_valid_i && req_kind_i == REF_DATA &&
         req_mode_i == AM_BASED_IDX && !req_base_frame_i && !req_idx_dest_i)
        |=> eff_addr_o == 16'($past(base_gp_reg) + $past(src_idx_reg)))
        else $error("based indexed offset wrong");

    phys_form_a: assert property (
        req_valid_i |=> phys_addr_o ==
            20'({$past(cur_seg_val), 4'h0} + {4'h0, $past(off_val)}))
        else $error("physical address wrong");

    opnd_imm_a: assert property (
        (opnd_req_i && opnd_imm_sel_i)
        |-> ##2 opnd_valid_o && opnd_data_o == $past(opnd_imm_i, 2))
        else $error("immediate operand not returned");

endmodule

`default_nettype wire

// [hw/sag_pkg.sv]
// constants, types and helper functions of the segmented address generator
// assumes one core clock domain; included before every other design file
`default_nettype none

package sag_pkg;

    // =====================================================================
    // widths and reset values
    localparam int WORD_W = 16;
    localparam int PHYS_W = 20;
    localparam int SEG_SHIFT = 4;
    localparam int NUM_GP = 8;
    localparam int NUM_SEG = 4;
    localparam logic [15:0] GP_RESET = 16'h0000;
    localparam logic [15:0] SEG_RESET = 16'h0000;
    localparam logic [15:0] INSTR_PTR_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // =====================================================================
    // general register indices; the first four split into two bytes
    localparam logic [2:0] GP_ACCUM = 3'h0;
    localparam logic [2:0] GP_COUNT = 3'h1;
    localparam logic [2:0] GP_DATA = 3'h2;
    localparam logic [2:0] GP_BASE = 3'h3;
    localparam logic [2:0] GP_STACK = 3'h4;
    localparam logic [2:0] GP_FRAME = 3'h5;
    localparam logic [2:0] GP_SRC_IDX = 3'h6;
    localparam logic [2:0] GP_DEST_IDX = 3'h7;

    // =====================================================================
    // segment register codes, reference kinds, addressing modes
    typedef enum logic [1:0] {
        SEG_EXTRA = 2'h0,
        SEG_CODE = 2'h1,
        SEG_STACK = 2'h2,
        SEG_DATA = 2'h3
    } sag_seg_e;

    typedef enum logic [2:0] {
        REF_FETCH = 3'h0,
        REF_IMMED = 3'h1,
        REF_STACK = 3'h2,
        REF_STR_DST = 3'h3,
        REF_DATA = 3'h4
    } sag_ref_e;

    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0,
        AM_REG_IND = 3'h1,
        AM_BASED = 3'h2,
        AM_INDEXED = 3'h3,
        AM_BASED_IDX = 3'h4,
        AM_BASED_IDX_DISP = 3'h5
    } sag_mode_e;

    // register picked by register indirect mode
    typedef enum logic [1:0] {
        RI_SRC_IDX = 2'h0,
        RI_DEST_IDX = 2'h1,
        RI_BASE = 2'h2,
        RI_FRAME = 2'h3
    } sag_ri_e;

    // =====================================================================
    // helpers
    function automatic logic [15:0] sag_sext8(input logic [7:0] b);
        sag_sext8 = {{8{b[7]}}, b};
    endfunction

    // carry out of bit 19 falls away
    function automatic logic [19:0] sag_phys(input logic [15:0] seg,
                                             input logic [15:0] off);
        sag_phys = {seg, 4'h0} + {4'h0, off};
    endfunction

endpackage

`default_nettype wire

// [hw/sag_gp_file.sv]
// the eight general registers with word and byte writes
// assumes writes come from the execution logic on the core clock
`default_nettype none

module sag_gp_file
    import sag_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic wr_byte_i,
    input wire logic wr_hi_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [2:0] rd_idx_i,
    output logic [15:0] rd_data_o,
    output logic [15:0] base_gp_o,
    output logic [15:0] frame_base_o,
    output logic [15:0] src_idx_o,
    output logic [15:0] dest_idx_o,
    output logic [15:0] stack_ptr_o
);

    // =====================================================================
    // storage
    logic [15:0] regs [NUM_GP];
    logic [15:0] next_regs [NUM_GP];
    logic [15:0] next_rd_data;
    logic [2:0] byte_idx;

    always_comb begin
        for (int i = 0; i < NUM_GP; i++) begin
            next_regs[i] = regs[i];
        end
        // byte writes reach only the four split registers
        byte_idx = {1'b0, wr_idx_i[1:0]};
        if (wr_en_i && wr_byte_i) begin
            if (wr_hi_i) begin
                next_regs[byte_idx][15:8] = wr_data_i[7:0];
            end else begin
                next_regs[byte_idx][7:0] = wr_data_i[7:0];
            end
        end else if (wr_en_i) begin
            next_regs[wr_idx_i] = wr_data_i;
        end
        next_rd_data = regs[rd_idx_i];
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_GP; i++) begin
                regs[i] <= GP_RESET;
            end
            rd_data_o <= GP_RESET;
        end else begin
            for (int i = 0; i < NUM_GP; i++) begin
                regs[i] <= next_regs[i];
            end
            rd_data_o <= next_rd_data;
        end
    end

    assign base_gp_o = regs[GP_BASE];
    assign frame_base_o = regs[GP_FRAME];
    assign src_idx_o = regs[GP_SRC_IDX];
    assign dest_idx_o = regs[GP_DEST_IDX];
    assign stack_ptr_o = regs[GP_STACK];

    // =====================================================================
    // checks
    lo_byte_keep_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_en_i && wr_byte_i && !wr_hi_i)
        |=> regs[$past(byte_idx)] ==
            {$past(regs[byte_idx][15:8]), $past(wr_data_i[7:0])})
        else $error("low byte write disturbed high byte");

    hi_byte_keep_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_en_i && wr_byte_i && wr_hi_i)
        |=> regs[$past(byte_idx)] ==
            {$past(wr_data_i[7:0]), $past(regs[byte_idx][7:0])})
        else $error("high byte write disturbed low byte");

    word_write_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_en_i && !wr_byte_i) ##1 (!wr_en_i)
        |=> regs[$past(wr_idx_i, 2)] == $past(wr_data_i, 2))
        else $error("word write not held");

endmodule

`default_nettype wire

// [hw/sag_seg_sel.sv]
// picks the segment register for one memory reference
// assumes kind, mode and override come straight from the decoder
`default_nettype none

module sag_seg_sel
    import sag_pkg::*;
(
    input wire sag_ref_e kind_i,
    input wire sag_mode_e mode_i,
    input wire logic base_frame_i,
    input wire sag_ri_e ri_sel_i,
    input wire logic ovr_valid_i,
    input wire sag_seg_e ovr_seg_i,
    output sag_seg_e seg_o
);

    // =====================================================================
    // selection
    logic uses_frame;

    always_comb begin
        case (mode_i)
            AM_BASED, AM_BASED_IDX, AM_BASED_IDX_DISP: begin
                uses_frame = base_frame_i;
            end
            AM_REG_IND: begin
                uses_frame = (ri_sel_i == RI_FRAME);
            end
            default: begin
                uses_frame = 1'b0;
            end
        endcase
        case (kind_i)
            REF_FETCH, REF_IMMED: begin
                seg_o = SEG_CODE;
            end
            REF_STACK: begin
                seg_o = SEG_STACK;
            end
            REF_STR_DST: begin
                // string destination stays fixed, prefixes do not move it
                seg_o = SEG_EXTRA;
            end
            default: begin
                if (ovr_valid_i) begin
                    seg_o = ovr_seg_i;
                end else if (uses_frame) begin
                    seg_o = SEG_STACK;
                end else begin
                    seg_o = SEG_DATA;
                end
            end
        endcase
    end

endmodule

`default_nettype wire

// [bench/sag_biu_model.sv]
// bus interface side model: keeps the last physical address handed over
// assumes addr_valid_i is a one-cycle pulse on the core clock
`default_nettype none

module sag_biu_model
    import sag_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic addr_valid_i,
    input wire logic [19:0] phys_addr_i,
    output logic [19:0] last_phys_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================================
    // capture
    // takes the address only on the pulse, as a bus cycle start would
    always @(posedge core_clk_i) begin
        if (addr_valid_i) begin
            last_phys_o <= phys_addr_i;
        end
    end
endmodule

`default_nettype wire

// [bench/sag_addr_gen_bench.sv]
// self-checking bench of the segmented address generator
// assumes the design package is compiled first; drives on falling edges
`default_nettype none

module sag_addr_gen_bench
    import sag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = '0, arst_n_i, gp_wr_en_i = '0, gp_wr_byte_i = '0;
    logic gp_wr_hi_i = '0, seg_wr_en_i = '0, instr_ptr_wr_en_i = '0;
    logic flags_wr_en_i = '0, opnd_req_i = '0, opnd_imm_sel_i = '0;
    logic opnd_byte_i = '0, opnd_hi_i = '0, req_valid_i = '0;
    logic req_base_frame_i = '0, req_idx_dest_i = '0, req_disp_wide_i = '0;
    logic req_ovr_valid_i = '0, opnd_valid_o, addr_valid_o;
    logic [2:0] gp_wr_idx_i = '0, opnd_reg_idx_i = '0;
    logic [15:0] gp_wr_data_i = '0, seg_wr_data_i = '0, flags_wr_data_i = '0;
    logic [15:0] instr_ptr_wr_data_i = '0, opnd_imm_i = 16'h5a5a;
    logic [15:0] req_disp_i = '0, opnd_data_o, eff_addr_o, instr_ptr_o;
    logic [15:0] flags_o;
    logic [19:0] phys_addr_o, last_phys;
    sag_seg_e seg_wr_sel_i = SEG_EXTRA, req_ovr_seg_i = SEG_EXTRA, seg_used_o;
    sag_ref_e req_kind_i = REF_DATA;
    sag_mode_e req_mode_i = AM_DIRECT;
    sag_ri_e req_ri_sel_i = RI_SRC_IDX;
    logic [15:0] sv [4] = '{16'h1000, 16'hf000, 16'h2000, 16'hffff};
    logic [15:0] gv [8] = '{16'h1234, 16'h7f7f, 16'h0, 16'hfff0, 16'h0ffe,
                           16'h0200, 16'h0030, 16'h0004};
    int miscompares = 0;
    int total_checks = 0;

    sag_addr_gen dut_u (.core_clk_i, .arst_n_i, .gp_wr_en_i, .gp_wr_idx_i,
        .gp_wr_byte_i, .gp_wr_hi_i, .gp_wr_data_i, .seg_wr_en_i,
        .seg_wr_sel_i, .seg_wr_data_i, .instr_ptr_wr_en_i,
        .instr_ptr_wr_data_i, .flags_wr_en_i, .flags_wr_data_i, .opnd_req_i,
        .opnd_imm_sel_i, .opnd_imm_i, .opnd_reg_idx_i, .opnd_byte_i,
        .opnd_hi_i, .req_valid_i, .req_kind_i, .req_mode_i, .req_base_frame_i,
        .req_idx_dest_i, .req_ri_sel_i, .req_disp_i, .req_disp_wide_i,
        .req_ovr_valid_i, .req_ovr_seg_i, .opnd_valid_o, .opnd_data_o,
        .addr_valid_o, .eff_addr_o, .phys_addr_o, .seg_used_o, .instr_ptr_o,
        .flags_o);
    sag_biu_model biu_u (.core_clk_i(core_clk_i),
        .addr_valid_i(addr_valid_o), .phys_addr_i(phys_addr_o),
        .last_phys_o(last_phys));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    // =====================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [19:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr_gp(input logic [2:0] i, input logic b, h,
                         input logic [15:0] d);
        gp_wr_idx_i = i;
        gp_wr_byte_i = b;
        gp_wr_hi_i = h;
        gp_wr_data_i = d;
        gp_wr_en_i = 1'h1;
        @(negedge core_clk_i);
        gp_wr_en_i = 1'h0;
        @(negedge core_clk_i);
    endtask

    // operand shows on the edge after the taking edge
    task automatic opnd(input logic m, input logic [2:0] i, input logic b, h,
                        input logic [15:0] e);
        opnd_imm_sel_i = m;
        opnd_reg_idx_i = i;
        opnd_byte_i = b;
        opnd_hi_i = h;
        opnd_req_i = 1'h1;
        @(negedge core_clk_i);
        opnd_req_i = 1'h0;
        @(negedge core_clk_i);
        chk("opnd_valid", opnd_valid_o, 1'h1);
        chk("opnd_data", opnd_data_o, e);
    endtask

    // sel packs base-frame, index-dest and the indirect pick; d[16] is wide
    task automatic areq(input sag_ref_e k, input sag_mode_e m,
        input logic [3:0] sel, input logic [16:0] d, input sag_seg_e sg,
        input logic [15:0] ee);
        logic [19:0] ep;
        ep = {sv[sg], 4'h0} + {4'h0, ee};
        req_kind_i = k;
        req_mode_i = m;
        req_base_frame_i = sel[3];
        req_idx_dest_i = sel[2];
        req_ri_sel_i = sag_ri_e'(sel[1:0]);
        req_disp_i = d[15:0];
        req_disp_wide_i = d[16];
        req_valid_i = 1'h1;
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
        chk("addr_valid", addr_valid_o, 1'h1);
        chk("eff_addr", eff_addr_o, ee);
        chk("seg_used", seg_used_o, sg);
        chk("phys_addr", phys_addr_o, ep);
        @(negedge core_clk_i);
        chk("addr_pulse", addr_valid_o, 1'h0);
        chk("biu_phys", last_phys, ep);
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset();
        arst_n_i = 1'h0;
        repeat (3) @(negedge core_clk_i);
        chk("rst_seg", seg_used_o, SEG_DATA);
        chk("rst_eff", eff_addr_o, 16'h0);
        chk("rst_ptr", instr_ptr_o, 16'h0);
        arst_n_i = 1'h1;
    endtask

    task automatic t_regs();
        for (int s = 0; s < 4; s++) begin
            seg_wr_sel_i = sag_seg_e'(s);
            seg_wr_data_i = sv[s];
            seg_wr_en_i = 1'h1;
            @(negedge core_clk_i);
        end
        seg_wr_en_i = 1'h0;
        for (int g = 0; g < 8; g++) wr_gp(g[2:0], 1'h0, 1'h0, gv[g]);
        wr_gp(3'h0, 1'h1, 1'h1, 16'hffab);
        wr_gp(3'h5, 1'h1, 1'h0, 16'h00cd); // byte index folds onto count
        instr_ptr_wr_data_i = 16'h1234;
        flags_wr_data_i = 16'h0ad5;
        instr_ptr_wr_en_i = 1'h1;
        flags_wr_en_i = 1'h1;
        @(negedge core_clk_i);
        instr_ptr_wr_en_i = 1'h0;
        flags_wr_en_i = 1'h0;
        chk("flags", flags_o, 16'h0ad5);
        chk("ptr", instr_ptr_o, 16'h1234);
        opnd(1'h0, 3'h0, 1'h0, 1'h0, 16'hab34);
        opnd(1'h0, 3'h1, 1'h1, 1'h0, 16'h00cd);
        opnd(1'h0, 3'h0, 1'h1, 1'h1, 16'h00ab);
        opnd(1'h1, 3'h0, 1'h0, 1'h0, 16'h5a5a);
        opnd(1'h0, 3'h3, 1'h0, 1'h0, 16'hfff0);
    endtask

    task automatic t_modes();
        areq(REF_DATA, AM_DIRECT, 4'h0, 17'h80, SEG_DATA,
            16'hff80);
        areq(REF_DATA, AM_DIRECT, 4'h0, 17'h11280, SEG_DATA,
            16'h1280);
        areq(REF_DATA, AM_REG_IND, 4'h0, 17'h0, SEG_DATA,
            16'h0030);
        areq(REF_DATA, AM_REG_IND, 4'h3, 17'h0, SEG_STACK,
            16'h0200);
        areq(REF_DATA, AM_BASED, 4'h0, 17'h20, SEG_DATA,
            16'h0010);
        areq(REF_DATA, AM_BASED, 4'h8, 17'hff, SEG_STACK,
            16'h01ff);
        areq(REF_DATA, AM_INDEXED, 4'h4, 17'h10100, SEG_DATA,
            16'h0104);
        areq(REF_DATA, AM_BASED_IDX, 4'h0, 17'h1234, SEG_DATA,
            16'h0020);
        areq(REF_DATA, AM_BASED_IDX_DISP, 4'hc, 17'h10010, SEG_STACK,
            16'h0214);
    endtask

    task automatic t_kinds();
        areq(REF_FETCH, AM_DIRECT, 4'h0, 17'h0, SEG_CODE,
            16'h1234);
        areq(REF_STACK, AM_DIRECT, 4'h0, 17'h0, SEG_STACK,
            16'h0ffe);
        areq(REF_STR_DST, AM_DIRECT, 4'h0, 17'h0, SEG_EXTRA,
            16'h0004);
        req_ovr_valid_i = 1'h1;
        req_ovr_seg_i = SEG_STACK;
        areq(REF_IMMED, AM_DIRECT, 4'h0, 17'h0, SEG_CODE,
            16'h1234);
        for (int s = 0; s < 4; s++) begin
            req_ovr_seg_i = sag_seg_e'(s);
            areq(REF_DATA, AM_BASED, 4'h8, 17'h40, sag_seg_e'(s),
                16'h0240);
        end
        req_ovr_valid_i = 1'h0;
        areq(REF_DATA, AM_DIRECT, 4'h0, 17'h10020, SEG_DATA,
            16'h0020);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        complete_run();
    end

    initial begin
        t_reset();
        t_regs();
        t_modes();
        t_kinds();
        t_reset();
        complete_run();
    end
endmodule

`default_nettype wire
